// file: rtl/asgw_map.svh
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef ASGW_MAP_SVH
`define ASGW_MAP_SVH
`define ASGW_OFF_CFG        8'h00
`define ASGW_OFF_GAIN_HI    8'h04
`define ASGW_OFF_GAIN_LO    8'h08
`define ASGW_OFF_GAIN_ADD   8'h0c
`define ASGW_OFF_THR_LO     8'h10
`define ASGW_OFF_THR_HI     8'h14
`define ASGW_OFF_RESULT     8'h18
`define ASGW_OFF_CTRL       8'h1c
`define ASGW_OFF_INT_STAT   8'h20
`define ASGW_OFF_INT_MASK   8'h24
`define ASGW_RST_GAIN_HI    8'hfc
`define ASGW_RST_GAIN_LO    8'h00
`define ASGW_RST_GAIN_ADD   1'h1
`define ASGW_TRACK_EXTRA    5'h02
`define ASGW_SAR_BITS       4'hd
`define ASGW_STEP_DONE      4'he
`define ASGW_MODE_POST      2'h1
`define ASGW_MODE_DUAL      2'h3
`define ASGW_INT_DONE       0
`define ASGW_INT_WIN        1
`define ASGW_RESP_OKAY      2'h0
`define ASGW_RESP_SLVERR    2'h2
`endif

// file: rtl/asgw_pkg.sv
// Types shared by the sequencer design
`default_nettype none
package asgw_pkg;
  // Sequencer states, Gray coded along idle, track, convert
  typedef enum logic [1:0] {
    ASGW_IDLE  = 2'h0,
    ASGW_TRACK = 2'h1,
    ASGW_CONV  = 2'h3
  } asgw_state_t;
  // Converter configuration word
  typedef struct packed {
    logic [3:0] trk_time;   // Tracking time setting
    logic [1:0] trk_mode;   // Tracking mode field
    logic [4:0] clk_div;    // Conversion clock divider
    logic       burst_sel;  // Burst clock select
  } asgw_cfg_t;
  // Gain settings
  typedef struct packed {
    logic [7:0] upper;      // Gain upper byte
    logic [3:0] lower;      // Gain lower nibble, bits 7..4
    logic       extra;      // Extra gain enable
  } asgw_gain_t;
endpackage : asgw_pkg
`default_nettype wire

// file: rtl/asgw_top.sv
// Converter sequencer with clock select, gain scaling and window compare
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`include "asgw_map.svh"
`default_nettype none
module asgw_top (
  input  wire logic        SYS_CLK_IN,        // System clock, 10 MHz
  input  wire logic        RST_N_IN,          // Synchronous reset, active low
  input  wire logic        BURST_OSC_IN,      // Burst oscillator, asynchronous
  input  wire logic        WIN_OUTSIDE_IN,    // 1: outside-window compare
  input  wire logic [11:0] RAW_RESULT_IN,     // Code from the analog core
  output logic             TRACK_OUT,         // Sampling capacitor connected
  output logic             CONV_START_OUT,    // Pulse: core starts a conversion
  output logic             SAR_CLK_OUT,       // Pulse per conversion clock
  output logic             IRQ_OUT,           // Level interrupt
  input  wire logic [7:0]  AXI_AWADDR_IN,
  input  wire logic        AXI_AWVALID_IN,
  output logic             AXI_AWREADY_OUT,
  input  wire logic [31:0] AXI_WDATA_IN,
  input  wire logic [3:0]  AXI_WSTRB_IN,
  input  wire logic        AXI_WVALID_IN,
  output logic             AXI_WREADY_OUT,
  output logic [1:0]       AXI_BRESP_OUT,
  output logic             AXI_BVALID_OUT,
  input  wire logic        AXI_BREADY_IN,
  input  wire logic [7:0]  AXI_ARADDR_IN,
  input  wire logic        AXI_ARVALID_IN,
  output logic             AXI_ARREADY_OUT,
  output logic [31:0]      AXI_RDATA_OUT,
  output logic [1:0]       AXI_RRESP_OUT,
  output logic             AXI_RVALID_OUT,
  input  wire logic        AXI_RREADY_IN
);
  import asgw_pkg::*;

  // ************************************************************
  // Registers and internal signals
  // ************************************************************
  asgw_cfg_t   cfg_ff;              // Converter configuration
  asgw_gain_t  gain_ff;             // Gain settings
  logic [11:0] thr_lo_ff;           // Lower threshold pair
  logic [11:0] thr_hi_ff;           // Upper threshold pair
  logic [11:0] result_ff;           // Conversion result word
  logic [1:0]  int_stat_ff;         // Sticky events
  logic [1:0]  int_mask_ff;         // Interrupt enables
  logic        start_ff;            // Convert start request
  asgw_state_t state_ff;            // Sequencer state
  logic [4:0]  trk_cnt_ff;          // Tracking clocks so far
  logic [3:0]  step_ff;             // Conversion step
  logic [4:0]  div_cnt_ff;          // Divider count
  logic [2:0]  osc_sync_ff;         // Burst oscillator synchroniser
  logic        osc_lvl_ff;          // Filtered oscillator level
  logic        converter_subsystem_clock_tick;           // Subsystem clock edge
  logic        sar_tick;            // Conversion clock edge
  logic        done;                // Conversion completes
  logic [11:0] gain_word;           // 12-bit gain word
  logic [23:0] prod;                // Result times gain word
  logic [12:0] scaled;              // Scaled result before clamping
  logic        win_hit;             // Window condition met
  logic        aw_got_ff;           // Write address held
  logic        w_got_ff;            // Write data held
  logic [7:0]  waddr_ff;            // Held write address
  logic [31:0] wdata_ff;            // Held write data
  logic        wr_do;               // Write executes this cycle
  logic        wr_map;              // Write address is mapped
  logic        rd_map;              // Read address is mapped
  logic [31:0] rd_val;              // Read mux output

  // ************************************************************
  // Subsystem clock selection
  // ************************************************************
  // Oscillator pin passes three flops; the level moves once stages two and
  // three agree, so a single metastable sample cannot make a false edge
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      osc_sync_ff <= 3'h0;
      osc_lvl_ff  <= 1'h0;
    end else begin
      osc_sync_ff <= {osc_sync_ff[1:0], BURST_OSC_IN};
      if (osc_sync_ff[1] == osc_sync_ff[2]) begin
        osc_lvl_ff <= osc_sync_ff[2];
      end
    end
  end

  // System clock ticks every cycle; burst source on each rising level.
  // Limitation: the burst source must run well below the system clock.
  assign converter_subsystem_clock_tick = cfg_ff.burst_sel ?
                     (osc_sync_ff[2] & osc_sync_ff[1] & ~osc_lvl_ff) : 1'h1;

  // ************************************************************
  // Conversion clock divider
  // ************************************************************
  // Runs only through the bit steps so each conversion starts phase aligned
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      div_cnt_ff <= 5'h0;
    end else if (state_ff != ASGW_CONV || step_ff == 4'h0) begin
      div_cnt_ff <= 5'h0;
    end else if (converter_subsystem_clock_tick) begin
      div_cnt_ff <= sar_tick ? 5'h0 : div_cnt_ff + 5'h1;
    end
  end
  // One conversion clock per divider plus one subsystem clocks
  assign sar_tick = converter_subsystem_clock_tick && state_ff == ASGW_CONV && step_ff != 4'h0 &&
                    step_ff != `ASGW_STEP_DONE && div_cnt_ff == cfg_ff.clk_div;

  // ************************************************************
  // Sequencer
  // ************************************************************
  assign done = state_ff == ASGW_CONV && step_ff == `ASGW_STEP_DONE && converter_subsystem_clock_tick;

  // Three states only; starts arriving while busy are dropped
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      state_ff   <= ASGW_IDLE;
      trk_cnt_ff <= 5'h0;
      step_ff    <= 4'h0;
    end else begin
      case (state_ff)
        ASGW_IDLE: begin
          trk_cnt_ff <= 5'h0;
          step_ff    <= 4'h0;
          if (start_ff) begin
            // Modes 01 and 11 track in hardware, others convert at once
            if (cfg_ff.trk_mode == `ASGW_MODE_POST ||
                cfg_ff.trk_mode == `ASGW_MODE_DUAL) begin
              state_ff <= ASGW_TRACK;
            end else begin
              state_ff <= ASGW_CONV;
            end
          end
        end
        ASGW_TRACK: begin
          if (converter_subsystem_clock_tick) begin
            if (trk_cnt_ff + 5'h1 == {1'h0, cfg_ff.trk_time} + `ASGW_TRACK_EXTRA) begin
              state_ff <= ASGW_CONV;
            end
            trk_cnt_ff <= trk_cnt_ff + 5'h1;
          end
        end
        ASGW_CONV: begin
          // Step 0 starts, steps 1..13 take one conversion clock, 14 completes
          if (done) begin
            state_ff <= ASGW_IDLE;
          end else if ((step_ff == 4'h0 && converter_subsystem_clock_tick) || sar_tick) begin
            step_ff <= step_ff + 4'h1;
          end
        end
        default: begin
          state_ff <= ASGW_IDLE;
        end
      endcase
    end
  end

  // Pin side: start pulse, conversion clock and sampling switch
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      CONV_START_OUT <= 1'h0;
      SAR_CLK_OUT    <= 1'h0;
      TRACK_OUT      <= 1'h0;
    end else begin
      CONV_START_OUT <= state_ff == ASGW_CONV && step_ff == 4'h0 && converter_subsystem_clock_tick;
      SAR_CLK_OUT    <= sar_tick;
      // Post mode keeps the input open while idle, dual and pre track
      TRACK_OUT <= (state_ff == ASGW_TRACK) ||
                   (state_ff == ASGW_IDLE && cfg_ff.trk_mode != `ASGW_MODE_POST);
    end
  end

  // ************************************************************
  // Gain scaling and window compare
  // ************************************************************
  assign gain_word = {gain_ff.upper, gain_ff.lower};
  assign prod      = RAW_RESULT_IN * gain_word;
  // Extra one sixty-fourth is the raw code shifted by six
  assign scaled = {1'h0, prod[23:12]} +
                  (gain_ff.extra ? {7'h0, RAW_RESULT_IN[11:6]} : 13'h0);

  // Strict compares against the clamped result of this conversion, before it is stored
  always_comb begin
    logic [11:0] r;
    r = scaled[12] ? 12'hfff : scaled[11:0];
    if (WIN_OUTSIDE_IN) begin
      win_hit = r < thr_lo_ff || r > thr_hi_ff;
    end else begin
      win_hit = r > thr_lo_ff && r < thr_hi_ff;
    end
  end

  // Result is held unsigned, clamped to the full-scale code fff
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      result_ff <= 12'h0;
    end else if (done) begin
      result_ff <= scaled[12] ? 12'hfff : scaled[11:0];
    end
  end

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  // Address and data are taken in either order; response follows both
  assign wr_do  = aw_got_ff && w_got_ff && !AXI_BVALID_OUT;
  assign wr_map = waddr_ff[7:2] <= `ASGW_OFF_INT_MASK >> 2 && waddr_ff[1:0] == 2'h0 &&
                  waddr_ff != `ASGW_OFF_RESULT;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      aw_got_ff       <= 1'h0;
      w_got_ff        <= 1'h0;
      waddr_ff        <= 8'h0;
      wdata_ff        <= 32'h0;
      AXI_AWREADY_OUT <= 1'h0;
      AXI_WREADY_OUT  <= 1'h0;
      AXI_BVALID_OUT  <= 1'h0;
      AXI_BRESP_OUT   <= `ASGW_RESP_OKAY;
    end else begin
      AXI_AWREADY_OUT <= !aw_got_ff && !(AXI_AWVALID_IN && AXI_AWREADY_OUT);
      AXI_WREADY_OUT  <= !w_got_ff && !(AXI_WVALID_IN && AXI_WREADY_OUT);
      if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
        aw_got_ff <= 1'h1;
        waddr_ff  <= AXI_AWADDR_IN;
      end
      if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
        w_got_ff <= 1'h1;
        wdata_ff <= AXI_WDATA_IN & {{8{AXI_WSTRB_IN[3]}}, {8{AXI_WSTRB_IN[2]}},
                                    {8{AXI_WSTRB_IN[1]}}, {8{AXI_WSTRB_IN[0]}}};
      end
      if (wr_do) begin
        aw_got_ff      <= 1'h0;
        w_got_ff       <= 1'h0;
        AXI_BVALID_OUT <= 1'h1;
        AXI_BRESP_OUT  <= wr_map ? `ASGW_RESP_OKAY : `ASGW_RESP_SLVERR;
      end else if (AXI_BVALID_OUT && AXI_BREADY_IN) begin
        AXI_BVALID_OUT <= 1'h0;
      end
    end
  end

  // ************************************************************
  // Software registers
  // ************************************************************
  // Configuration, gain, thresholds; unstrobed lanes write zero-masked data
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      cfg_ff      <= '0;
      gain_ff     <= '{upper: `ASGW_RST_GAIN_HI, lower: 4'(`ASGW_RST_GAIN_LO >> 4),
                       extra: `ASGW_RST_GAIN_ADD};
      thr_lo_ff   <= 12'h0;
      thr_hi_ff   <= 12'hfff;
      int_mask_ff <= 2'h0;
    end else if (wr_do) begin
      case (waddr_ff)
        `ASGW_OFF_CFG:      cfg_ff       <= asgw_cfg_t'(wdata_ff[11:0]);
        `ASGW_OFF_GAIN_HI:  gain_ff.upper <= wdata_ff[7:0];
        `ASGW_OFF_GAIN_LO:  gain_ff.lower <= wdata_ff[7:4];
        `ASGW_OFF_GAIN_ADD: gain_ff.extra <= wdata_ff[0];
        `ASGW_OFF_THR_LO:   thr_lo_ff    <= wdata_ff[11:0];
        `ASGW_OFF_THR_HI:   thr_hi_ff    <= wdata_ff[11:0];
        `ASGW_OFF_INT_MASK: int_mask_ff  <= wdata_ff[1:0];
        default: begin
        end
      endcase
    end
  end

  // Convert start: one-cycle request from a control write
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      start_ff <= 1'h0;
    end else begin
      start_ff <= wr_do && waddr_ff == `ASGW_OFF_CTRL && wdata_ff[0];
    end
  end

  // ************************************************************
  // Interrupt status
  // ************************************************************
  // Write one to clear; an event in the clearing cycle wins
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      int_stat_ff <= 2'h0;
      IRQ_OUT     <= 1'h0;
    end else begin
      int_stat_ff[`ASGW_INT_DONE] <= done ||
        (int_stat_ff[`ASGW_INT_DONE] &&
         !(wr_do && waddr_ff == `ASGW_OFF_INT_STAT && wdata_ff[`ASGW_INT_DONE]));
      int_stat_ff[`ASGW_INT_WIN] <= (done && win_hit) ||
        (int_stat_ff[`ASGW_INT_WIN] &&
         !(wr_do && waddr_ff == `ASGW_OFF_INT_STAT && wdata_ff[`ASGW_INT_WIN]));
      IRQ_OUT <= |(int_stat_ff & int_mask_ff);
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  assign rd_map = AXI_ARADDR_IN[7:2] <= `ASGW_OFF_INT_MASK >> 2 && AXI_ARADDR_IN[1:0] == 2'h0;

  always_comb begin
    case (AXI_ARADDR_IN)
      `ASGW_OFF_CFG:      rd_val = {20'h0, cfg_ff};
      `ASGW_OFF_GAIN_HI:  rd_val = {24'h0, gain_ff.upper};
      `ASGW_OFF_GAIN_LO:  rd_val = {24'h0, gain_ff.lower, 4'h0};
      `ASGW_OFF_GAIN_ADD: rd_val = {31'h0, gain_ff.extra};
      `ASGW_OFF_THR_LO:   rd_val = {20'h0, thr_lo_ff};
      `ASGW_OFF_THR_HI:   rd_val = {20'h0, thr_hi_ff};
      `ASGW_OFF_RESULT:   rd_val = {20'h0, result_ff};
      `ASGW_OFF_CTRL:     rd_val = {29'h0, state_ff, state_ff != ASGW_IDLE};
      `ASGW_OFF_INT_STAT: rd_val = {30'h0, int_stat_ff};
      `ASGW_OFF_INT_MASK: rd_val = {30'h0, int_mask_ff};
      default:            rd_val = 32'h0;
    endcase
  end

  // Address taken while no read data is pending; data the next cycle
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      AXI_ARREADY_OUT <= 1'h0;
      AXI_RVALID_OUT  <= 1'h0;
      AXI_RDATA_OUT   <= 32'h0;
      AXI_RRESP_OUT   <= `ASGW_RESP_OKAY;
    end else begin
      AXI_ARREADY_OUT <= !AXI_RVALID_OUT && !(AXI_ARVALID_IN && AXI_ARREADY_OUT);
      if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
        AXI_RVALID_OUT <= 1'h1;
        AXI_RDATA_OUT  <= rd_val;
        AXI_RRESP_OUT  <= rd_map ? `ASGW_RESP_OKAY : `ASGW_RESP_SLVERR;
      end else if (AXI_RVALID_OUT && AXI_RREADY_IN) begin
        AXI_RVALID_OUT <= 1'h0;
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  logic [5:0] chk_trk_ff;           // Cycles spent tracking
  logic [3:0] chk_sar_ff;           // Conversion clocks this conversion
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN || state_ff == ASGW_IDLE) begin
      chk_trk_ff <= 6'h0;
      chk_sar_ff <= 4'h0;
    end else begin
      chk_trk_ff <= chk_trk_ff + (state_ff == ASGW_TRACK ? 6'h1 : 6'h0);
      chk_sar_ff <= chk_sar_ff + (sar_tick ? 4'h1 : 4'h0);
    end
  end

  a_clk_select: assert property (!cfg_ff.burst_sel |-> converter_subsystem_clock_tick)
    else $error("System clock source not ticking every cycle");
  a_state_legal: assert property (state_ff inside {ASGW_IDLE, ASGW_TRACK, ASGW_CONV})
    else $error("Sequencer in illegal state");
  a_pre_direct: assert property (state_ff == ASGW_IDLE && start_ff &&
    cfg_ff.trk_mode != `ASGW_MODE_POST && cfg_ff.trk_mode != `ASGW_MODE_DUAL
    |=> state_ff == ASGW_CONV)
    else $error("Pre-tracking start did not convert at once");
  a_track_len: assert property (state_ff == ASGW_TRACK && $stable(cfg_ff) && !cfg_ff.burst_sel
    ##1 state_ff == ASGW_CONV |-> chk_trk_ff == {2'h0, cfg_ff.trk_time} + 6'h2)
    else $error("Tracking length wrong");
  a_track_to_conv: assert property (state_ff == ASGW_TRACK |=> state_ff != ASGW_IDLE)
    else $error("Tracking ended without converting");
  a_conv_len: assert property (done |-> chk_sar_ff == 4'hd &&
    (cfg_ff.burst_sel || $past(step_ff) == 4'hd))
    else $error("Conversion did not take 13 conversion clocks");
  a_post_hold: assert property (state_ff == ASGW_IDLE && cfg_ff.trk_mode == `ASGW_MODE_POST
    ##1 state_ff == ASGW_IDLE |-> !TRACK_OUT)
    else $error("Post mode tracked while idle");
  a_dual_track: assert property (state_ff == ASGW_IDLE && cfg_ff.trk_mode == `ASGW_MODE_DUAL
    ##1 state_ff == ASGW_IDLE |-> TRACK_OUT)
    else $error("Dual mode stopped tracking while idle");
  a_window_set: assert property (done && win_hit |=> int_stat_ff[`ASGW_INT_WIN])
    else $error("Window hit not flagged");
  a_window_cause: assert property ($rose(int_stat_ff[`ASGW_INT_WIN]) |-> $past(done))
    else $error("Window flag set without a conversion");
  a_irq_level: assert property (|(int_stat_ff & int_mask_ff) |=> IRQ_OUT)
    else $error("Interrupt not raised");

  c_pre_conv: cover property (state_ff == ASGW_IDLE && start_ff ##1 state_ff == ASGW_CONV);
  c_track_conv: cover property (state_ff == ASGW_TRACK ##1 state_ff == ASGW_CONV);
  c_window_hit: cover property (done && win_hit);
endmodule : asgw_top
`default_nettype wire

// file: sim/asgw_core_model.sv
// Behavioural model of the analog converter core behind the sequencer
`default_nettype none
module asgw_core_model (
  input  wire logic        clk_in,    // System clock
  input  wire logic        rst_n_in,  // Synchronous reset, active low
  input  wire logic        start_in,  // Conversion start pulse
  input  wire logic        sar_in,    // Conversion clock pulse
  input  wire logic [11:0] code_in,   // Analog level as a code
  output logic      [11:0] raw_out    // Code handed to the sequencer
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  bits_ff;  // Bits resolved so far
  logic [11:0] held_ff;  // Level frozen at start
  // Count resolved bits; restart on every start
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bits_ff <= 4'h0;
    end else if (start_in) begin
      bits_ff <= 4'h0;
      held_ff <= code_in;
    end else if (sar_in && bits_ff != 4'hf) begin
      bits_ff <= bits_ff + 4'h1;
    end
  end
  // Unresolved word shows the inverse so a premature sample is caught
  assign raw_out = (bits_ff >= 4'hc) ? held_ff : ~held_ff;
endmodule // asgw_core_model
`default_nettype wire

// file: sim/asgw_tb.sv
// Self-checking bench of the converter sequencer
`include "asgw_map.svh"
`default_nettype none
module adc_sequencer_gain_window_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, osc = 0, osc_run = 0, win_out = 0;
  logic [11:0] code = 12'h000, raw;
  logic trk, cst, sar, irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic awv = 0, awr, wv = 0, wr_r, bv, br = 0, arv = 0, arr, rv, rr = 0;
  logic [1:0] bresp, rresp, rd_r, wb;
  int miscompares = 0, n_compared = 0, cyc = 0, nsar = 0, ntrk = 0, first = 0, last = 0, mark = 0;
  int s0, t0, ncst = 0, c0 = 0;
  always #50 clk = ~clk;
  // Cycle, pulse and tracking counters; burst oscillator at one eighth of the clock
  always @(posedge clk) begin
    cyc++;
    if (sar === 1'b1) begin
      if (nsar == mark) first = cyc;
      last = cyc;
      nsar++;
    end
    if (trk === 1'b1) ntrk++;
    if (cst === 1'b1) ncst++;
    if (osc_run && cyc % 4 == 0) osc <= ~osc;
  end
  asgw_top uut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .BURST_OSC_IN(osc),
    .WIN_OUTSIDE_IN(win_out), .RAW_RESULT_IN(raw), .TRACK_OUT(trk), .CONV_START_OUT(cst),
    .SAR_CLK_OUT(sar), .IRQ_OUT(irq), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awv),
    .AXI_AWREADY_OUT(awr), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hf), .AXI_WVALID_IN(wv),
    .AXI_WREADY_OUT(wr_r), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(br),
    .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
    .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rr));
  asgw_core_model core (.clk_in(clk), .rst_n_in(rst_n), .start_in(cst), .sar_in(sar),
    .code_in(code), .raw_out(raw));
  task automatic final_report();
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait expired
  task automatic hang();
    miscompares++;
    $display("MISMATCH timeout expected answer seen none");
    final_report();
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awv <= 1; wv <= 1; br <= 1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 0;
      if (wv && wr_r) wv <= 0;
    end while (bv !== 1'b1 && n < 50);
    wb = bresp;
    br <= 0;
    if (n >= 50) hang();
  endtask
  task automatic rd(input logic [7:0] a);
    int n = 0;
    @(posedge clk);
    araddr <= a; arv <= 1; rr <= 1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 0;
    end while (rv !== 1'b1 && n < 50);
    rd_v = rdata; rd_r = rresp; rr <= 0;
    if (n >= 50) hang();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk("register", e, rd_v);
  endtask
  task automatic wait_idle();
    int n = 0;
    do begin rd(`ASGW_OFF_CTRL); n++; end while (rd_v[0] !== 1'b0 && n < 200);
    if (n >= 200) hang();
  endtask
  task automatic conv(input logic [11:0] r);
    // One edge first, so pin levels of the previous mode are not counted
    @(posedge clk);
    code <= r; mark = nsar; s0 = nsar; t0 = ntrk; c0 = ncst;
    wr(`ASGW_OFF_CTRL, 32'h1);
    wait_idle();
  endtask
  // Scaled result: word/4096 plus optional one sixty-fourth, clamped
  function automatic logic [31:0] scale(logic [11:0] r, logic [11:0] g, logic e);
    logic [31:0] v = ((r * g) >> 12) + (e ? (r >> 6) : 0);
    return (v > 32'hfff) ? 32'hfff : v;
  endfunction
  logic [7:0]  g_hi[4] = '{8'hfc, 8'h7c, 8'hff, 8'hff};
  logic [7:0]  g_lo[4] = '{8'h00, 8'h00, 8'hf0, 8'hf0};
  logic        g_ad[4] = '{1, 1, 1, 0};
  logic [11:0] w_raw[6] = '{12'h180, 12'h100, 12'h200, 12'h0ff, 12'h210, 12'h180};
  logic        w_out[6] = '{0, 0, 0, 1, 1, 1};
  logic        f;
  logic [31:0] res;
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    rdc(`ASGW_OFF_GAIN_HI, 32'hfc);
    rdc(`ASGW_OFF_GAIN_LO, 32'h00);
    rdc(`ASGW_OFF_GAIN_ADD, 32'h1);
    rdc(`ASGW_OFF_THR_HI, 32'hfff);
    rd(8'h40);
    chk("unmapped resp", `ASGW_RESP_SLVERR, rd_r);
    wr(`ASGW_OFF_RESULT, 32'h5);
    chk("result write resp", `ASGW_RESP_SLVERR, wb);
    rdc(`ASGW_OFF_RESULT, 32'h0);
    wr(`ASGW_OFF_CFG, 32'h0);
    chk("write resp", `ASGW_RESP_OKAY, wb);
    for (int i = 0; i < 4; i++) begin
      wr(`ASGW_OFF_GAIN_HI, g_hi[i]);
      wr(`ASGW_OFF_GAIN_LO, g_lo[i]);
      wr(`ASGW_OFF_GAIN_ADD, g_ad[i]);
      conv(12'hfff);
      rdc(`ASGW_OFF_RESULT, scale(12'hfff, {g_hi[i], g_lo[i][7:4]}, g_ad[i]));
    end
    wr(`ASGW_OFF_CFG, 32'h2);
    conv(12'h800);
    chk("sar pulses", 13, nsar - s0);
    chk("start pulses", 1, ncst - c0);
    chk("sar spacing", 24, last - first);
    wr(`ASGW_OFF_CFG, 32'h540);
    conv(12'h800);
    chk("track cycles", 7, ntrk - t0);
    chk("post idle track", 0, trk);
    wr(`ASGW_OFF_CFG, 32'h5c0);
    conv(12'h800);
    chk("dual idle track", 1, trk);
    wr(`ASGW_OFF_CFG, 32'h0);
    wr(`ASGW_OFF_GAIN_HI, 32'hfc);
    wr(`ASGW_OFF_GAIN_LO, 32'h00);
    wr(`ASGW_OFF_GAIN_ADD, 32'h1);
    wr(`ASGW_OFF_THR_LO, 32'h100);
    wr(`ASGW_OFF_THR_HI, 32'h200);
    wr(`ASGW_OFF_INT_MASK, 32'h2);
    for (int i = 0; i < 6; i++) begin
      wr(`ASGW_OFF_INT_STAT, 32'h3);
      win_out <= w_out[i];
      conv(w_raw[i]);
      res = scale(w_raw[i], 12'hfc0, 1'b1);
      f = w_out[i] ? (res < 32'h100 || res > 32'h200) : (res > 32'h100 && res < 32'h200);
      rd(`ASGW_OFF_INT_STAT);
      chk("window flag", f, rd_v[1]);
      chk("irq", f, irq);
    end
    conv(12'h800);
    rd(`ASGW_OFF_INT_STAT);
    chk("sticky flag", 1, rd_v[1]);
    wr(`ASGW_OFF_INT_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("masked irq", 0, irq);
    wr(`ASGW_OFF_INT_STAT, 32'h3);
    rdc(`ASGW_OFF_INT_STAT, 32'h0);
    wr(`ASGW_OFF_CFG, 32'h1);
    code <= 12'h400;
    wr(`ASGW_OFF_CTRL, 32'h1);
    repeat (30) @(posedge clk);
    rd(`ASGW_OFF_CTRL);
    chk("burst stalled busy", 1, rd_v[0]);
    osc_run <= 1;
    wait_idle();
    rdc(`ASGW_OFF_RESULT, scale(12'h400, 12'hfc0, 1'b1));
    final_report();
  end
endmodule // adc_sequencer_gain_window_tb
`default_nettype wire
